/* exp_io_pkg.sv */
// shared constants for the expanded i/o channel scan sequencer
// assumes a 25 MHz system clock and a 32-bit ahb-lite register bus
package exp_io_pkg;

  // clocking and scan timing
  localparam int CLK_FREQ_MHZ = 25;
  localparam int SCAN_TIME_US = 6000;
  localparam int SCAN_CYCLES  = SCAN_TIME_US * CLK_FREQ_MHZ;
  localparam int CODE_TIME_NS = 160;
  localparam int CODE_CYCLES  = (CODE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // channel space: eight main channels, each paired with an aux channel
  localparam int MAIN_CHANS = 8;
  localparam int ALL_CHANS  = 16;
  localparam int CHAN_W     = 3;
  localparam int DATA_W     = 8;
  localparam logic [3:0] AUX_BASE = 4'h8;

  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CHAN_EN = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_SWEEPS  = 8'h0c;
  localparam logic [1:0] TBL_REGS    = 2'h0;
  localparam logic [1:0] TBL_OUT     = 2'h1;
  localparam logic [1:0] TBL_IN      = 2'h2;
  localparam logic [1:0] TBL_COIL    = 2'h3;

  // control fields
  localparam int CTRL_EXP_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] CHAN_EN_RESET = 8'h00;

  // status fields
  localparam int STAT_SCAN_BIT = 0;
  localparam int STAT_CODE_BIT = 1;
  localparam int STAT_CHAN_LSB = 4;
  localparam int STAT_LOCK_BIT = 8;
  localparam int STAT_RUN_BIT  = 9;
  localparam int STAT_STOP_BIT = 10;

  // ahb-lite encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CODE,
    ST_SCAN
  } scan_state_e;

endpackage : exp_io_pkg

/* chan_pick.sv */
// finds the lowest enabled main channel above i_from, or from channel 0 when i_first is set
// purely combinational; used by the scan sequencer for its ordering
module chan_pick
  import exp_io_pkg::*;
#(
  parameter int N = MAIN_CHANS,
  parameter int W = CHAN_W
) (
  // enable mask and search start
  input  wire logic [N-1:0] i_en,
  input  wire logic [W-1:0] i_from,
  input  wire logic         i_first,
  // result
  output logic              o_found,
  output logic [W-1:0]      o_chan
);
  import exp_io_pkg::*;

  logic [W:0] start;

  always_comb begin
    start   = i_first ? '0 : ({1'b0, i_from} + (W+1)'(1));
    o_found = 1'b0;
    o_chan  = '0;
    // walk downward so the lowest match is kept last
    for (int i = N - 1; i >= 0; i--) begin
      if (i_en[i] && ((W+1)'(i) >= start)) begin
        o_found = 1'b1;
        o_chan  = W'(i);
      end
    end
  end

endmodule : chan_pick

/* exp_io_scan.sv */
// expanded i/o scan sequencer with ahb-lite register slave
// assumes a single ahb-lite master, word transfers, and synchronous pins
//
// Behaviour
// RULE1 - in expanded mode, put out a channel code, then do a full scan
// RULE2 - visit enabled channels in ascending order, lowest first
// RULE3 - each channel scan lasts six to seven ms; sweep grows with channels
// RULE4 - enabling a main channel also scans its paired aux channel together
// RULE5 - internal coil points need no configuration or channel enable
// RULE6 - transmitters offer a jumper choice of expanded or normal mode
// RULE7 - expanded transmitters forward traffic only when their channel matches
// RULE8 - transmitter channel comes from three backplane switches
// RULE9 - exactly one transmitter decodes any given channel
// RULE10 - undecoded devices see every enabled channel's traffic
// RULE11 - transmitters below a decoding one stay in normal mode
// RULE12 - channel data never appears below a transmitter of another channel
// RULE13 - channel code stays readable so bus controllers can self-decode
// RULE14 - parity drop out of run locks ports until stop then power cycle
// RULE15 - sixteen channels: eight main, eight auxiliary
// RULE16 - decoding transmitters compare code with switches every scan
//
// Chosen here: register access over AHB-Lite and the register addresses.
module exp_io_scan
  import exp_io_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_CYCLES,
  parameter int CODE_CYC = CODE_CYCLES
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic [31:0]            o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // keyswitch and memory check
  input  wire logic              i_key_run,
  input  wire logic              i_parity_err,
  // parallel i/o chains
  output logic [CHAN_W-1:0]      o_chan_code,
  output logic                   o_code_valid,
  output logic                   o_scan_active,
  output logic [DATA_W-1:0]      o_main_out,
  output logic [DATA_W-1:0]      o_aux_out,
  input  wire logic [DATA_W-1:0] i_main_in,
  input  wire logic [DATA_W-1:0] i_aux_in,
  // run state
  output logic                   o_run_active,
  output logic                   o_ports_locked
);
  import exp_io_pkg::*;

  function automatic logic [3:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[5:2];
  endfunction : word_index

  function automatic logic [1:0] table_sel(input logic [ADDR_W-1:0] a);
    table_sel = a[7:6];
  endfunction : table_sel

  // software visible state
  logic [1:0]              ctrl_q;
  logic [MAIN_CHANS-1:0]   chan_en_q;
  logic [31:0]             sweeps_q;
  logic [DATA_W-1:0]       out_tbl_q  [ALL_CHANS];
  logic [DATA_W-1:0]       in_tbl_q   [ALL_CHANS];
  logic [DATA_W-1:0]       coil_q     [ALL_CHANS];

  // run, lock and sequencer state
  logic                    run_q;
  logic                    lock_q;
  logic                    stop_seen_q;
  scan_state_e             state_q;
  logic [31:0]             cnt_q;
  logic [CHAN_W-1:0]       chan_q;

  // bus pipeline
  logic                    wr_pend_q;
  logic [ADDR_W-1:0]       wr_addr_q;
  logic                    addr_ok;
  logic [ADDR_W-1:0]       a_addr;
  logic [31:0]             rd_word;
  logic [31:0]             status;

  logic                    expanded;
  logic                    pick_first;
  logic                    pick_found;
  logic [CHAN_W-1:0]       pick_chan;
  logic                    code_done;
  logic                    scan_done;
  logic [3:0]              aux_idx;

  assign expanded  = ctrl_q[CTRL_EXP_BIT];
  assign code_done = (cnt_q == 32'(CODE_CYC - 1));
  assign scan_done = (cnt_q == 32'(SCAN_CYC - 1));
  assign aux_idx   = AUX_BASE | {1'b0, chan_q}; // RULE4 RULE15
  assign a_addr    = i_haddr[ADDR_W-1:0];
  assign addr_ok   = i_hsel && i_hready && i_htrans[HTRANS_ACTIVE_BIT];

  chan_pick #(
    .N (MAIN_CHANS),
    .W (CHAN_W)
  ) u_pick (
    .i_en    (chan_en_q),
    .i_from  (chan_q),
    .i_first (pick_first),
    .o_found (pick_found),
    .o_chan  (pick_chan)
  );

  assign pick_first = (state_q == ST_IDLE);

  // run / lock control: a parity drop locks the ports; only a reset
  // (power cycle) clears the lock, and run needs the key seen at stop
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stop_seen_q <= 1'b0;
    end else if (!i_key_run) begin
      stop_seen_q <= 1'b1; // RULE14
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_q <= 1'b0;
    end else if (run_q && i_parity_err) begin
      lock_q <= 1'b1; // RULE14
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_q <= 1'b0;
    end else if (i_parity_err || !i_key_run || lock_q) begin
      run_q <= 1'b0; // RULE14
    end else if (ctrl_q[CTRL_RUN_BIT] && stop_seen_q) begin
      run_q <= 1'b1;
    end
  end

  // scan sequencer
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      chan_q  <= '0;
    end else if (!run_q || i_parity_err) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (!expanded) begin
            // normal mode: one plain scan, no channel code
            chan_q  <= '0;
            state_q <= ST_SCAN;
          end else if (pick_found) begin
            chan_q  <= pick_chan; // RULE2
            state_q <= ST_CODE; // RULE1
          end
        end
        ST_CODE: begin
          if (code_done) begin
            cnt_q   <= '0;
            state_q <= ST_SCAN; // RULE1
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_SCAN: begin
          if (scan_done) begin
            cnt_q <= '0; // RULE3
            if (expanded && pick_found) begin
              chan_q  <= pick_chan; // RULE2
              state_q <= ST_CODE;
            end else begin
              state_q <= ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sweeps_q <= '0;
    end else if (run_q && !i_parity_err && state_q == ST_SCAN && scan_done
                 && !(expanded && pick_found)) begin
      sweeps_q <= sweeps_q + 32'h1;
    end
  end

  // chain pins; data only moves while its own channel is coded, so a
  // decoding transmitter never passes another channel's bytes downstream
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_chan_code   <= '0;
      o_code_valid  <= 1'b0;
      o_scan_active <= 1'b0;
      o_main_out    <= '0;
      o_aux_out     <= '0;
    end else begin
      // code held through the whole scan for self-decoding controllers
      o_chan_code   <= chan_q; // RULE13
      o_code_valid  <= expanded && (state_q != ST_IDLE); // RULE1 RULE13
      o_scan_active <= (state_q == ST_SCAN); // RULE10
      if (state_q == ST_SCAN) begin
        o_main_out <= out_tbl_q[{1'b0, chan_q}]; // RULE12
        o_aux_out  <= out_tbl_q[aux_idx]; // RULE4
      end else begin
        o_main_out <= '0; // RULE12
        o_aux_out  <= '0;
      end
    end
  end

  // input capture at the end of each channel scan, both chains at once
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < ALL_CHANS; i++) begin
        in_tbl_q[i] <= '0;
      end
    end else if (run_q && state_q == ST_SCAN && scan_done) begin
      in_tbl_q[{1'b0, chan_q}] <= i_main_in; // RULE12
      in_tbl_q[aux_idx]        <= i_aux_in; // RULE4
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_run_active   <= 1'b0;
      o_ports_locked <= 1'b0;
    end else begin
      o_run_active   <= run_q;
      o_ports_locked <= lock_q; // RULE14
    end
  end

  // ahb-lite: zero wait states; read data is formed from the address
  // phase so it can leave a flip-flop in the data phase
  always_comb begin
    status = '0;
    status[STAT_SCAN_BIT] = (state_q == ST_SCAN);
    status[STAT_CODE_BIT] = (state_q == ST_CODE);
    status[STAT_CHAN_LSB +: CHAN_W] = chan_q;
    status[STAT_LOCK_BIT] = lock_q;
    status[STAT_RUN_BIT]  = run_q;
    status[STAT_STOP_BIT] = stop_seen_q;
  end

  always_comb begin
    rd_word = '0;
    unique case (table_sel(a_addr))
      TBL_REGS: begin
        unique case (a_addr)
          REG_CTRL:    rd_word = {30'h0, ctrl_q};
          REG_CHAN_EN: rd_word = {24'h0, chan_en_q};
          REG_STATUS:  rd_word = status;
          REG_SWEEPS:  rd_word = sweeps_q;
          default:     rd_word = '0;
        endcase
      end
      TBL_OUT:  rd_word = {24'h0, out_tbl_q[word_index(a_addr)]};
      TBL_IN:   rd_word = {24'h0, in_tbl_q[word_index(a_addr)]};
      TBL_COIL: rd_word = {24'h0, coil_q[word_index(a_addr)]}; // RULE5
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata    <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= HRESP_OKAY;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= '0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= HRESP_OKAY;
      wr_pend_q   <= addr_ok && i_hwrite;
      if (addr_ok) begin
        wr_addr_q <= a_addr;
      end
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_word;
      end
    end
  end

  // register writes are refused while the ports are locked
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q    <= CTRL_RESET;
      chan_en_q <= CHAN_EN_RESET;
    end else if (wr_pend_q && !lock_q) begin // RULE14
      if (wr_addr_q == REG_CTRL) begin
        ctrl_q <= i_hwdata[1:0];
      end
      if (wr_addr_q == REG_CHAN_EN) begin
        chan_en_q <= i_hwdata[MAIN_CHANS-1:0]; // RULE4
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < ALL_CHANS; i++) begin
        out_tbl_q[i] <= '0;
        coil_q[i]    <= '0;
      end
    end else if (wr_pend_q && !lock_q) begin
      if (table_sel(wr_addr_q) == TBL_OUT) begin
        out_tbl_q[word_index(wr_addr_q)] <= i_hwdata[DATA_W-1:0];
      end
      // coils work with no mode or channel enable at all
      if (table_sel(wr_addr_q) == TBL_COIL) begin
        coil_q[word_index(wr_addr_q)] <= i_hwdata[DATA_W-1:0]; // RULE5
      end
    end
  end

endmodule : exp_io_scan

/* exp_io_scan_checker.sv */
// concurrent checks on the pins of the expanded i/o scan sequencer
// assumes one clock domain and the asynchronous active-low reset
module exp_io_scan_checker
  import exp_io_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_CYCLES,
  parameter int CODE_CYC = CODE_CYCLES
) (
  // clock and reset
  input wire logic              i_sys_clk,
  input wire logic              i_reset_n,
  // watched pins
  input wire logic              i_parity_err,
  input wire logic              o_hreadyout,
  input wire logic              o_hresp,
  input wire logic [CHAN_W-1:0] o_chan_code,
  input wire logic              o_code_valid,
  input wire logic              o_scan_active,
  input wire logic [DATA_W-1:0] o_main_out,
  input wire logic [DATA_W-1:0] o_aux_out,
  input wire logic              o_run_active,
  input wire logic              o_ports_locked
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  // scan length counter; an aborted scan is excused by the run drop
  int scan_cnt_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scan_cnt_q <= 0;
    end else if (o_scan_active) begin
      scan_cnt_q <= scan_cnt_q + 1;
    end else begin
      scan_cnt_q <= 0;
    end
  end

  a_bus_ready_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus slave not ready or not okay");
  // code phase is exactly four cycles before the scan phase
  a_code_then_scan: assert property ($rose(o_code_valid) |->
    !o_scan_active [*4] ##1 o_scan_active)
    else $error("code phase length wrong");
  a_code_held: assert property (o_scan_active && o_code_valid
    |-> $stable(o_chan_code))
    else $error("channel code moved during scan");
  a_chan_ascend: assert property (o_code_valid && $past(o_code_valid)
    && (o_chan_code != $past(o_chan_code))
    |-> o_chan_code > $past(o_chan_code))
    else $error("channel order not ascending");
  a_scan_length: assert property ($fell(o_scan_active) && o_run_active
    |-> scan_cnt_q == SCAN_CYC)
    else $error("scan phase length wrong");
  a_outs_held: assert property (o_scan_active && $past(o_scan_active)
    |-> $stable(o_main_out) && $stable(o_aux_out))
    else $error("chain outputs moved during scan");
  a_outs_idle: assert property (!o_scan_active
    |-> o_main_out == 8'h00 && o_aux_out == 8'h00)
    else $error("chain outputs driven outside scan");
  a_lock_stays: assert property (o_ports_locked |=> o_ports_locked)
    else $error("port lock released without reset");
  a_lock_no_run: assert property (o_ports_locked |-> !o_run_active)
    else $error("running while locked");
  a_parity_drop: assert property (i_parity_err && o_run_active
    |-> ##[1:2] !o_run_active)
    else $error("parity error did not stop run");
  a_parity_lock: assert property (i_parity_err && o_run_active
    |-> ##[1:2] o_ports_locked)
    else $error("parity error did not lock ports");
endmodule : exp_io_scan_checker

bind exp_io_scan exp_io_scan_checker #(
  .SCAN_CYC(SCAN_CYC),
  .CODE_CYC(CODE_CYC)
) chk (
  .i_sys_clk     (i_sys_clk),
  .i_reset_n     (i_reset_n),
  .i_parity_err  (i_parity_err),
  .o_hreadyout   (o_hreadyout),
  .o_hresp       (o_hresp),
  .o_chan_code   (o_chan_code),
  .o_code_valid  (o_code_valid),
  .o_scan_active (o_scan_active),
  .o_main_out    (o_main_out),
  .o_aux_out     (o_aux_out),
  .o_run_active  (o_run_active),
  .o_ports_locked(o_ports_locked)
);

/* xmtr_model.sv */
// behavioural channel-decoding transmitter with its rack of modules
// assumes the chain pins of the sequencer; input lines have pull-ups
module xmtr_model #(
  parameter logic [2:0] SW    = 3'h0,
  parameter logic       EXP   = 1'b1,
  parameter logic [7:0] REPLY = 8'h00
) (
  // chain from the cpu
  input  wire logic [2:0] i_chan_code,
  input  wire logic       i_scan_active,
  input  wire logic [7:0] i_out,
  // downstream segment and returned inputs
  output logic [7:0]      o_down,
  output logic [7:0]      o_in
);
  logic sel;
  // jumper picks normal or decoding; switches give the channel
  assign sel = !EXP || (i_chan_code == SW);
  assign o_down = (sel && i_scan_active) ? i_out : 8'h00;
  // released lines float to the pull-up level, not the last value
  assign o_in = (sel && i_scan_active) ? REPLY : 8'hff;
endmodule : xmtr_model

/* tb.sv */
// self-checking bench for the expanded i/o scan sequencer
// assumes ahb-lite word access and two decoding transmitters downstream
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import exp_io_pkg::*;
  localparam int SC = 20;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, key, perr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, code;
  logic        cv, sa, run, lock;
  logic [7:0]  mo, ao, mi, ai, dm, da;
  int          errors, compares;
  logic [2:0]  ch [2] = '{3'h2, 3'h5};
  logic [7:0]  em [2] = '{8'h11, 8'h33};
  logic [7:0]  ea [2] = '{8'h22, 8'h44};

  exp_io_scan #(.SCAN_CYC(SC), .CODE_CYC(4)) dut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_key_run(key),
    .i_parity_err(perr), .o_chan_code(code), .o_code_valid(cv),
    .o_scan_active(sa), .o_main_out(mo), .o_aux_out(ao), .i_main_in(mi),
    .i_aux_in(ai), .o_run_active(run), .o_ports_locked(lock));
  // one decoder per channel: main chain channel 5, aux chain channel 10
  xmtr_model #(.SW(3'h5), .REPLY(8'hc5)) xm (
    .i_chan_code(code), .i_scan_active(sa), .i_out(mo), .o_down(dm),
    .o_in(mi));
  xmtr_model #(.SW(3'h2), .REPLY(8'ha2)) xa (
    .i_chan_code(code), .i_scan_active(sa), .i_out(ao), .o_down(da),
    .o_in(ai));

  always #20 clk = ~clk;

  task automatic complete_run;
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // waits for a bus slave or scan level, never longer than a bound
  task automatic wait_lvl(input logic sel_scan, input logic v,
                          output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel_scan ? sa : hready) !== v && n < 200);
    if (n >= 200) begin
      errors++;
      complete_run;
    end
  endtask : wait_lvl

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_lvl(1'b0, 1'b1, n);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_lvl(1'b0, 1'b1, n);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask : rdc

  initial begin
    int n;
    clk = 0; rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; key = 0; perr = 0; errors = 0; compares = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc(REG_CTRL, 32'h0);
    rdc(REG_CHAN_EN, 32'h0);
    rdc(8'h10, 32'h0);
    wr(8'hcc, 32'h5a);
    rdc(8'hcc, 32'h5a);
    check(run, 1'b0);
    wr(8'h7c, 32'hff);
    rdc(8'h7c, 32'hff);
    wr(8'h48, 32'h11);
    wr(8'h68, 32'h22);
    wr(8'h54, 32'h33);
    wr(8'h74, 32'h44);
    wr(REG_CHAN_EN, 32'h24);
    key <= 1'b1;
    wr(REG_CTRL, 32'h3);
    for (int i = 0; i < 2; i++) begin
      wait_lvl(1'b1, 1'b1, n);
      check(code, ch[i]);
      check(cv, 1'b1);
      check(mo, em[i]);
      check(ao, ea[i]);
      check(dm, i ? 8'h33 : 8'h00);
      check(da, i ? 8'h00 : 8'h22);
      wait_lvl(1'b1, 1'b0, n);
      check(n, SC);
    end
    wait_lvl(1'b1, 1'b1, n);
    check(code, 3'h2);
    rdc(REG_SWEEPS, 32'h1);
    rdc(8'h94, 32'hc5);
    rdc(8'h88, 32'hff);
    rdc(8'ha8, 32'ha2);
    rdc(8'hb4, 32'hff);
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    repeat (3) @(posedge clk);
    check(lock, 1'b1);
    check(run, 1'b0);
    wr(REG_CTRL, 32'h0);
    rdc(REG_CTRL, 32'h3);
    key <= 1'b0;
    repeat (3) @(posedge clk);
    key <= 1'b1;
    repeat (3) @(posedge clk);
    check(lock, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(lock, 1'b0);
    rdc(REG_CTRL, 32'h0);
    // normal mode after the power cycle: stop first, then one plain scan
    key <= 1'b0;
    wr(8'h40, 32'h5c);
    wr(8'h60, 32'h6d);
    key <= 1'b1;
    wr(REG_CTRL, 32'h2);
    wait_lvl(1'b1, 1'b1, n);
    check(cv, 1'b0);
    check(code, 3'h0);
    check(mo, 8'h5c);
    check(ao, 8'h6d);
    check(dm, 8'h00);
    rdc(REG_STATUS, 32'h601);
    wait_lvl(1'b1, 1'b0, n);
    check(n, SC - 2);
    rdc(REG_SWEEPS, 32'h1);
    complete_run;
  end
endmodule : tb
